// *** core/prt_consts.vh ***
// register map, field positions, reset values and timing counts of the trigger qualifier
`ifndef PRT_CONSTS_VH
`define PRT_CONSTS_VH

// register byte offsets
`define PRT_OFS_CTRL       8'h00
`define PRT_OFS_PAT_CARE   8'h04
`define PRT_OFS_PAT_LEVEL  8'h08
`define PRT_OFS_PAT_TIME   8'h0C
`define PRT_OFS_PAT_DELTA  8'h10
`define PRT_OFS_RUNT_WIDTH 8'h14
`define PRT_OFS_RUNT_DELTA 8'h18
`define PRT_OFS_RISE_TIME  8'h1C
`define PRT_OFS_RISE_DELTA 8'h20
`define PRT_OFS_TMO_TIME   8'h24
`define PRT_OFS_STATUS     8'h28

// control fields, lsb positions
`define PRT_CTRL_TYPE      0
`define PRT_CTRL_PMODE     2
`define PRT_CTRL_PRANGE    4
`define PRT_CTRL_PFUNC     6
`define PRT_CTRL_PCOND     7
`define PRT_CTRL_RRANGE    8
`define PRT_CTRL_RPOL      10
`define PRT_CTRL_FRANGE    11
`define PRT_CTRL_FSLOPE    13
`define PRT_CTRL_TLEVEL    14
`define PRT_CTRL_SRC       15
`define PRT_CTRL_DIGEN     17
`define PRT_CTRL_TWOCH     18
`define PRT_CTRL_WIDTH     19
`define PRT_CTRL_RESET     19'h00000

// trigger types
`define PRT_TYPE_PATTERN   2'h0
`define PRT_TYPE_RUNT      2'h1
`define PRT_TYPE_RISE      2'h2
`define PRT_TYPE_TIMEOUT   2'h3

// pattern time-limitation modes
`define PRT_PMODE_OFF      2'h0
`define PRT_PMODE_TIMEOUT  2'h1
`define PRT_PMODE_WIDTH    2'h2

// range comparison rules
`define PRT_RANGE_LONGER   2'h0
`define PRT_RANGE_SHORTER  2'h1
`define PRT_RANGE_WITHIN   2'h2
`define PRT_RANGE_OUTSIDE  2'h3

// pattern size
`define PRT_NUM_ANA        4
`define PRT_NUM_DIG        16
`define PRT_PAT_BITS       20

// timing, clock period in ns and timeout limits in ns and in clock cycles
`define PRT_CLK_PERIOD_NS  50
`define PRT_TMO_MIN_NS     3.2
`define PRT_TMO_DEF_NS     10000
`define PRT_TMO_MIN_CYC    1
`define PRT_TMO_DEF_CYC    (`PRT_TMO_DEF_NS / `PRT_CLK_PERIOD_NS)

`endif

// *** core/prt_trigger.v ***
// pattern, runt, rise/fall time and timeout trigger qualifier with ahb-lite registers
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`include "prt_consts.vh"
`default_nettype none

module prt_trigger (
	// clock, reset, enable
	input  wire        ref_clk,
	input  wire        reset_n,
	input  wire        clk_en,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// comparator results
	input  wire [3:0]  ana_above,
	input  wire [3:0]  ana_above_low,
	input  wire [3:0]  ana_above_high,
	input  wire [15:0] dig_above,
	// trigger out
	output reg         trig_pulse,
	output reg         pat_result
);

	// range rule shared by pattern width, runt and transition time
	function range_ok;
		input [1:0]  rule;
		input [31:0] dur;
		input [31:0] ref_t;
		input [31:0] delta;
		reg   [32:0] lo;
		reg   [32:0] hi;
		begin
			lo = {1'b0, ref_t} - {1'b0, delta};
			hi = {1'b0, ref_t} + {1'b0, delta};
			if (lo[32])
				lo = 33'h000000000;
			case (rule)
				`PRT_RANGE_LONGER:  range_ok = (dur > ref_t);
				`PRT_RANGE_SHORTER: range_ok = (dur < ref_t);
				`PRT_RANGE_WITHIN:  range_ok = ({1'b0, dur} > lo) && ({1'b0, dur} < hi);
				default:            range_ok = ({1'b0, dur} < lo) || ({1'b0, dur} > hi);
			endcase
		end
	endfunction

	// configuration registers
	reg  [18:0] ctrl_q;
	reg  [19:0] care_q;
	reg  [19:0] level_q;
	reg  [31:0] pat_time_q;
	reg  [31:0] pat_delta_q;
	reg  [31:0] runt_width_q;
	reg  [31:0] runt_delta_q;
	reg  [31:0] rise_time_q;
	reg  [31:0] rise_delta_q;
	reg  [31:0] tmo_time_q;

	// bus state
	reg         wr_pend_q;
	reg  [7:0]  wr_addr_q;

	// measurement state
	reg  [31:0] cnt_q;
	reg         act_q;
	reg         fired_q;
	reg         held_prev_q;
	reg         low_prev_q;
	reg         high_prev_q;
	reg  [15:0] trig_cnt_q;

	wire [1:0]  trig_type = ctrl_q[`PRT_CTRL_TYPE +: 2];
	wire [1:0]  pat_mode  = ctrl_q[`PRT_CTRL_PMODE +: 2];
	wire [1:0]  pat_range = ctrl_q[`PRT_CTRL_PRANGE +: 2];
	wire [1:0]  runt_rng  = ctrl_q[`PRT_CTRL_RRANGE +: 2];
	wire [1:0]  rise_rng  = ctrl_q[`PRT_CTRL_FRANGE +: 2];
	wire [1:0]  src       = ctrl_q[`PRT_CTRL_SRC +: 2];
	wire        runt_neg  = ctrl_q[`PRT_CTRL_RPOL];
	wire        fall_sel  = ctrl_q[`PRT_CTRL_FSLOPE];

	wire [19:0] size_mask = {{16{ctrl_q[`PRT_CTRL_DIGEN]}}, {2{~ctrl_q[`PRT_CTRL_TWOCH]}}, 2'h3};
	wire [19:0] used      = care_q & size_mask;
	wire [19:0] sample    = {dig_above, ana_above};
	// per entry match, ignored entries drop out
	wire [19:0] match     = ~(sample ^ level_q);
	wire        and_res   = &(match | ~used);
	wire        or_res    = |(match & used);
	wire        comb_res  = ctrl_q[`PRT_CTRL_PFUNC] ? or_res : and_res;
	wire        pat_now   = comb_res ^ ctrl_q[`PRT_CTRL_PCOND];

	// selected source comparators
	wire        lvl_now   = ana_above[src];
	wire        low_now   = ana_above_low[src];
	wire        high_now  = ana_above_high[src];
	wire        tmo_now   = lvl_now ^ ctrl_q[`PRT_CTRL_TLEVEL];

	wire        held_now  = (trig_type == `PRT_TYPE_TIMEOUT) ? tmo_now : pat_now;
	wire        held_chg  = held_now ^ held_prev_q;
	wire [31:0] cnt_inc   = (cnt_q == 32'hFFFFFFFF) ? cnt_q : cnt_q + 32'h00000001;

	wire        low_up    = low_now & ~low_prev_q;
	wire        low_dn    = ~low_now & low_prev_q;
	wire        high_up   = high_now & ~high_prev_q;
	wire        high_dn   = ~high_now & high_prev_q;

	// bus
	wire        addr_ph   = hsel & hready & htrans[1];
	assign hreadyout = clk_en;
	assign hresp     = 1'b0;

	// trigger decision
	reg         fire_d;
	reg         act_d;
	reg  [31:0] cnt_d;
	reg         fired_d;

	always @* begin
		fire_d  = 1'b0;
		act_d   = act_q;
		cnt_d   = cnt_inc;
		fired_d = fired_q;
		case (trig_type)
			`PRT_TYPE_PATTERN, `PRT_TYPE_TIMEOUT: begin
				if (held_chg) begin
					cnt_d   = 32'h00000001;
					fired_d = 1'b0;
				end
				if (trig_type == `PRT_TYPE_TIMEOUT) begin
					if (held_now && !fired_d && cnt_d >= tmo_time_q) begin
						fire_d  = 1'b1;
						fired_d = 1'b1;
					end
				end else begin
					case (pat_mode)
						`PRT_PMODE_OFF: begin
							fire_d = held_now & held_chg;
						end
						`PRT_PMODE_TIMEOUT: begin
							if (held_now && !fired_d && cnt_d >= pat_time_q) begin
								fire_d  = 1'b1;
								fired_d = 1'b1;
							end
						end
						`PRT_PMODE_WIDTH: begin
							// true duration judged at its end
							if (!held_now && held_prev_q)
								fire_d = range_ok(pat_range, cnt_q, pat_time_q, pat_delta_q);
						end
						default: fire_d = 1'b0;
					endcase
				end
			end
			`PRT_TYPE_RUNT: begin
				if (!runt_neg) begin
					// lower up then down, upper never
					if (high_now)
						act_d = 1'b0;
					else if (low_up) begin
						act_d = 1'b1;
						cnt_d = 32'h00000001;
					end else if (low_dn && act_q) begin
						act_d = 1'b0;
						fire_d = range_ok(runt_rng, cnt_q, runt_width_q, runt_delta_q);
					end
				end else begin
					// upper down then up, lower never
					if (!low_now)
						act_d = 1'b0;
					else if (high_dn) begin
						act_d = 1'b1;
						cnt_d = 32'h00000001;
					end else if (high_up && act_q) begin
						act_d = 1'b0;
						fire_d = range_ok(runt_rng, cnt_q, runt_width_q, runt_delta_q);
					end
				end
			end
			default: begin
				if (!fall_sel) begin
					// lower up starts, upper up stops
					if (low_up && !high_now) begin
						act_d = 1'b1;
						cnt_d = 32'h00000001;
					end else if (low_dn)
						act_d = 1'b0;
					else if (high_up && act_q) begin
						act_d = 1'b0;
						fire_d = range_ok(rise_rng, cnt_q, rise_time_q, rise_delta_q);
					end
				end else begin
					// upper down starts, lower down stops
					if (high_dn && low_now) begin
						act_d = 1'b1;
						cnt_d = 32'h00000001;
					end else if (high_up)
						act_d = 1'b0;
					else if (low_dn && act_q) begin
						act_d = 1'b0;
						fire_d = range_ok(rise_rng, cnt_q, rise_time_q, rise_delta_q);
					end
				end
			end
		endcase
	end

	// measurement and trigger registers
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_q       <= 32'h00000000;
			act_q       <= 1'b0;
			fired_q     <= 1'b0;
			held_prev_q <= 1'b0;
			low_prev_q  <= 1'b0;
			high_prev_q <= 1'b0;
			trig_pulse  <= 1'b0;
			pat_result  <= 1'b0;
			trig_cnt_q  <= 16'h0000;
		end else if (clk_en) begin
			cnt_q       <= cnt_d;
			act_q       <= act_d;
			fired_q     <= fired_d;
			held_prev_q <= held_now;
			low_prev_q  <= low_now;
			high_prev_q <= high_now;
			trig_pulse  <= fire_d;
			pat_result  <= pat_now;
			if (fire_d)
				trig_cnt_q <= trig_cnt_q + 16'h0001;
		end
	end

	// register read value, captured in the address phase
	reg [31:0] rd_d;
	always @* begin
		case (haddr)
			`PRT_OFS_CTRL:       rd_d = {13'h0000, ctrl_q};
			`PRT_OFS_PAT_CARE:   rd_d = {12'h000, care_q};
			`PRT_OFS_PAT_LEVEL:  rd_d = {12'h000, level_q};
			`PRT_OFS_PAT_TIME:   rd_d = pat_time_q;
			`PRT_OFS_PAT_DELTA:  rd_d = pat_delta_q;
			`PRT_OFS_RUNT_WIDTH: rd_d = runt_width_q;
			`PRT_OFS_RUNT_DELTA: rd_d = runt_delta_q;
			`PRT_OFS_RISE_TIME:  rd_d = rise_time_q;
			`PRT_OFS_RISE_DELTA: rd_d = rise_delta_q;
			`PRT_OFS_TMO_TIME:   rd_d = tmo_time_q;
			`PRT_OFS_STATUS:     rd_d = {trig_cnt_q, 13'h0000, act_q, held_now, pat_now};
			default:             rd_d = 32'h00000000;
		endcase
	end

	// bus slave; zero wait states while clk_en is high, unmapped reads zero and writes are dropped
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			wr_pend_q    <= 1'b0;
			wr_addr_q    <= 8'h00;
			hrdata       <= 32'h00000000;
			ctrl_q       <= `PRT_CTRL_RESET;
			care_q       <= 20'h00000;
			level_q      <= 20'h00000;
			pat_time_q   <= 32'h00000001;
			pat_delta_q  <= 32'h00000000;
			runt_width_q <= 32'h00000001;
			runt_delta_q <= 32'h00000000;
			rise_time_q  <= 32'h00000001;
			rise_delta_q <= 32'h00000000;
			tmo_time_q   <= `PRT_TMO_DEF_CYC;
		end else if (clk_en) begin
			wr_pend_q <= addr_ph & hwrite;
			wr_addr_q <= haddr;
			if (addr_ph && !hwrite)
				hrdata <= rd_d;
			if (wr_pend_q) begin
				case (wr_addr_q)
					`PRT_OFS_CTRL:       ctrl_q       <= hwdata[18:0];
					`PRT_OFS_PAT_CARE:   care_q       <= hwdata[19:0];
					`PRT_OFS_PAT_LEVEL:  level_q      <= hwdata[19:0];
					`PRT_OFS_PAT_TIME:   pat_time_q   <= hwdata;
					`PRT_OFS_PAT_DELTA:  pat_delta_q  <= hwdata;
					`PRT_OFS_RUNT_WIDTH: runt_width_q <= hwdata;
					`PRT_OFS_RUNT_DELTA: runt_delta_q <= hwdata;
					`PRT_OFS_RISE_TIME:  rise_time_q  <= hwdata;
					`PRT_OFS_RISE_DELTA: rise_delta_q <= hwdata;
					// timeout below one cycle is raised to one
					`PRT_OFS_TMO_TIME:   tmo_time_q   <= (hwdata == 32'h00000000) ? `PRT_TMO_MIN_CYC : hwdata;
					default:             wr_pend_q    <= 1'b0;
				endcase
			end
		end
	end

endmodule // prt_trigger

`default_nettype wire

// *** dv/prt_comp_model.sv ***
// comparator front end model: channel levels into threshold flags
`default_nettype none
module prt_comp_model (
	// clock
	input  wire logic        ref_clk,
	// two bits a channel: 0 below lower, 1 below level, 2 below upper, 3 above upper
	input  wire logic [7:0]  volts,
	input  wire logic [15:0] probes,
	// threshold flags
	output logic      [3:0]  ana_above,
	output logic      [3:0]  ana_above_low,
	output logic      [3:0]  ana_above_high,
	output logic      [15:0] dig_above
);
	timeunit 1ns;
	timeprecision 1ps;
	// flags settle at the sampling edge, never mid cycle
	always @(posedge ref_clk) begin
		for (int c = 0; c < 4; c++) begin
			ana_above_low[c]  <= volts[2*c +: 2] >= 2'h1;
			ana_above[c]      <= volts[2*c +: 2] >= 2'h2;
			ana_above_high[c] <= volts[2*c +: 2] == 2'h3;
		end
		dig_above <= probes;
	end
endmodule // prt_comp_model
`default_nettype wire

// *** dv/prt_trigger_sva.sv ***
// port checks of the trigger qualifier
`default_nettype none
module prt_trigger_sva (
	// clock, reset, enable
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	// bus
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// comparator and trigger
	input wire logic [3:0]  ana_above,
	input wire logic        trig_pulse,
	input wire logic        pat_result
);
	logic        wr_q;
	logic        hole_q;
	logic [18:0] ctrl_q;
	// control shadow, the live trigger type is not visible otherwise
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			wr_q   <= 1'b0;
			hole_q <= 1'b0;
			ctrl_q <= 19'h00000;
		end else if (clk_en) begin
			wr_q   <= hsel && htrans[1] && hwrite && haddr == 8'h00;
			hole_q <= hsel && htrans[1] && !hwrite && haddr > 8'h28;
			if (wr_q)
				ctrl_q <= hwdata[18:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_ready_en: assert property (hreadyout == clk_en)
		else $error("hreadyout differs from clk_en");
	a_resp_ok: assert property (!hresp)
		else $error("error response seen");
	a_reset_quiet: assert property (disable iff (1'b0) !reset_n && clk_en |=> !trig_pulse && !pat_result)
		else $error("outputs not cleared by reset");
	a_freeze_all: assert property (!clk_en |=> $stable(trig_pulse) && $stable(pat_result) && $stable(hrdata))
		else $error("state moved while disabled");
	a_hole_zero: assert property (hole_q |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_off_rise: assert property (ctrl_q[3:0] == 4'h0 && $rose(pat_result) |-> ##[0:1] trig_pulse)
		else $error("no pulse on pattern rise");
	a_off_true: assert property (ctrl_q[3:0] == 4'h0 && trig_pulse |-> pat_result)
		else $error("pulse without pattern result");
	a_tmo_held: assert property (ctrl_q[1:0] == 2'h3 && trig_pulse |->
		$past(ana_above[ctrl_q[16:15]]) != ctrl_q[14] && $past(ana_above[ctrl_q[16:15]], 2) != ctrl_q[14])
		else $error("timeout pulse without held level");
	c_runt: cover property (ctrl_q[1:0] == 2'h1 && trig_pulse);
	c_rise: cover property (ctrl_q[1:0] == 2'h2 && trig_pulse);
	c_tmo: cover property (ctrl_q[1:0] == 2'h3 && trig_pulse);
endmodule // prt_trigger_sva
bind prt_trigger prt_trigger_sva sva (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .ana_above(ana_above), .trig_pulse(trig_pulse), .pat_result(pat_result));
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench of the trigger qualifier
`include "prt_consts.vh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, reset_n, clk_en, hsel, hwrite, hreadyout, hresp, trig_pulse, pat_result;
	logic [7:0]  haddr, volts;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, rd;
	logic [15:0] probes, dig_above;
	logic [3:0]  ana_above, ana_above_low, ana_above_high;
	logic [11:0] exp_tab;
	int          fail_count, check_count;
	int          pulses = 0;
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (trig_pulse === 1'b1) pulses <= pulses + 1;
	prt_trigger dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ana_above(ana_above),
		.ana_above_low(ana_above_low), .ana_above_high(ana_above_high), .dig_above(dig_above),
		.trig_pulse(trig_pulse), .pat_result(pat_result));
	prt_comp_model model (.ref_clk(ref_clk), .volts(volts), .probes(probes), .ana_above(ana_above),
		.ana_above_low(ana_above_low), .ana_above_high(ana_above_high), .dig_above(dig_above));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_sim;
		if (fail_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// single transfer, waits on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		rd = hrdata;
		if (n >= 40) begin
			chk("bus wait", 32'h1, 32'h0);
			end_sim();
		end
	endtask
	task automatic pat(input logic [31:0] c, input logic [7:0] v, input logic [15:0] p, input logic e);
		bus(1'b1, `PRT_OFS_CTRL, c);
		volts  <= v;
		probes <= p;
		repeat (4) @(posedge ref_clk);
		chk("pattern result", {31'h0, pat_result}, {31'h0, e});
	endtask
	// channel one rests at base, sits at level 2 for d cycles, then fin, then base again
	task automatic shape(input int d, input logic [1:0] fin, input logic e, input logic [1:0] base = 2'h0);
		int p0;
		volts <= {6'h00, base};
		repeat (6) @(posedge ref_clk);
		p0 = pulses;
		volts <= 8'h02;
		repeat (d) @(posedge ref_clk);
		volts <= {6'h00, fin};
		@(posedge ref_clk);
		volts <= {6'h00, base};
		repeat (8) @(posedge ref_clk);
		chk("pulse count", 32'(pulses - p0), {31'h0, e});
	endtask
	initial begin
		{reset_n, hsel, hwrite, haddr, htrans, hwdata, volts, probes} = '0;
		clk_en = 1'b1;
		fail_count = 0;
		check_count = 0;
		exp_tab = 12'hA8E;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		bus(1'b0, `PRT_OFS_CTRL, 32'h0);
		chk("ctrl reset", rd, 32'h0);
		bus(1'b0, `PRT_OFS_TMO_TIME, 32'h0);
		chk("timeout reset", rd, 32'h000000C8);
		bus(1'b0, 8'h2C, 32'h0);
		chk("unmapped read", rd, 32'h0);
		bus(1'b1, `PRT_OFS_PAT_CARE, 32'h00013);
		bus(1'b1, `PRT_OFS_PAT_LEVEL, 32'h00011);
		bus(1'b0, `PRT_OFS_PAT_CARE, 32'h0);
		chk("care readback", rd, 32'h00013);
		pat(32'h20000, 8'h02, 16'h0001, 1'b1);
		pat(32'h20000, 8'h0A, 16'h0001, 1'b0);
		pat(32'h20000, 8'h32, 16'h0001, 1'b1);
		pat(32'h20040, 8'h08, 16'h0000, 1'b0);
		pat(32'h20040, 8'h00, 16'h0000, 1'b1);
		pat(32'h20080, 8'h0A, 16'h0001, 1'b1);
		pat(32'h00000, 8'h02, 16'h0000, 1'b1);
		// frozen clock must hold the old result
		clk_en <= 1'b0;
		volts  <= 8'h08;
		repeat (4) @(posedge ref_clk);
		chk("frozen result", {31'h0, pat_result}, 32'h1);
		clk_en <= 1'b1;
		volts  <= 8'h00;
		for (int k = 0; k < 6; k++)
			bus(1'b1, `PRT_OFS_PAT_TIME + 8'(4 * k), k[0] ? 32'h3 : 32'h8);
		for (int t = 0; t < 3; t++) begin
			for (int r = 0; r < 4; r++) begin
				bus(1'b1, `PRT_OFS_CTRL, 32'(t) | (t == 0 ? 32'h8 : 32'h0) | (32'(r) << (t == 0 ? 4 : t == 1 ? 8 : 11)));
				for (int i = 0; i < 3; i++)
					shape(3 + 6 * i - (i == 2 ? 2 : 0), t == 2 ? 2'h3 : 2'h0, exp_tab[r * 3 + i]);
			end
		end
		// pattern held true for at least the programmed time
		bus(1'b1, `PRT_OFS_CTRL, 32'h4);
		shape(10, 2'h0, 1'b1);
		shape(3, 2'h0, 1'b0);
		// negative runt dips below upper from a high rest
		bus(1'b1, `PRT_OFS_CTRL, 32'h401);
		shape(9, 2'h3, 1'b1, 2'h3);
		shape(3, 2'h3, 1'b0, 2'h3);
		// fall time from upper down to lower down
		bus(1'b1, `PRT_OFS_CTRL, 32'h2002);
		shape(9, 2'h0, 1'b1, 2'h3);
		shape(3, 2'h0, 1'b0, 2'h3);
		bus(1'b1, `PRT_OFS_TMO_TIME, 32'h3);
		bus(1'b1, `PRT_OFS_CTRL, 32'h3);
		shape(10, 2'h0, 1'b1);
		bus(1'b1, `PRT_OFS_CTRL, 32'h4003);
		shape(10, 2'h0, 1'b1);
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
